// File: hw/tbq_pkg.sv
// Purpose: Shared constants and carrier types for the timer block control.
// Assumes: One 32-bit AHB-Lite register window, byte addresses as printed.
// Notes:   Channel registers repeat every CH_STRIDE bytes for 3 channels.
package tbq_pkg;

  // Register byte addresses (channel 0 copy for per-channel registers)
  localparam logic [31:0] ADDR_IER0  = 32'h4001_0024; // Channel irq enable
  localparam logic [31:0] ADDR_IDR0  = 32'h4001_0028; // Channel irq disable
  localparam logic [31:0] ADDR_IMR0  = 32'h4001_002C; // Channel irq mask
  localparam logic [31:0] CH_STRIDE  = 32'h0000_0040; // Channel spacing
  localparam logic [31:0] ADDR_BCR   = 32'h4001_00C0; // Block control
  localparam logic [31:0] ADDR_BMR   = 32'h4001_00C4; // Block mode
  localparam logic [31:0] ADDR_QIER  = 32'h4001_00C8; // Decoder irq enable
  localparam logic [31:0] ADDR_QIDR  = 32'h4001_00CC; // Decoder irq disable
  localparam logic [31:0] ADDR_QIMR  = 32'h4001_00D0; // Decoder irq mask
  localparam logic [31:0] ADDR_WPMR  = 32'h4001_00E4; // Write protection

  // Field positions and masks
  localparam int unsigned   SYNC_BIT      = 0;              // Block control
  localparam int unsigned   WRITE_PROTECT_ENABLE_BIT      = 0;              // Protection
  localparam logic [31:0]   MODE_WMASK    = 32'h03F3_FF3F;  // Writable mode
  localparam logic [23:0]   WP_KEY        = 24'h54_494D;    // Unlock key
  localparam logic [7:0]    CAPTURE_ONLY  = 8'h62;          // Ovr, load A/B
  localparam logic [7:0]    WAVE_ONLY     = 8'h0C;          // Compare A/B

  // External clock selection codes
  localparam logic [1:0]    XSEL_PIN      = 2'h0;  // Dedicated clock pin
  localparam logic [1:0]    XSEL_ALT_LO   = 2'h2;  // Lower other channel
  localparam logic [1:0]    XSEL_ALT_HI   = 2'h3;  // Higher other channel

  // Values after reset
  localparam logic [7:0]    CHAN_MASK_RST = 8'h00;
  localparam logic [2:0]    QMASK_RST     = 3'h0;
  localparam logic [31:0]   MODE_RST      = 32'h0000_0000;
  localparam logic          WP_RST        = 1'b0;
  localparam logic [5:0]    FILT_CNT_RST  = 6'h00;

  // Block mode register, laid out bit for bit as the bus word
  typedef struct packed {
    logic [5:0] rsv_hi;
    logic [5:0] max_filter;
    logic [1:0] rsv_mid;
    logic       index_source_select;
    logic       swap;
    logic       invert_index;
    logic       invert_phase_b;
    logic       invert_phase_a;
    logic       edge_count_mode;
    logic       transparent_decoding;
    logic       speed_enable;
    logic       position_enable;
    logic       decoder_enable;
    logic [1:0] rsv_lo;
    logic [1:0] ext_clock2_select;
    logic [1:0] ext_clock1_select;
    logic [1:0] ext_clock0_select;
  } tbq_mode_t;

  // Decoder events, in decoder interrupt bit order
  typedef struct packed {
    logic quadrature_error;
    logic direction_change;
    logic index_input;
  } tbq_qevt_t;

endpackage

// File: hw/tbq_glitch_filter.sv
// Purpose: Discards input pulses shorter than max_filter+1 clock cycles.
// Assumes: Input is synchronous to clk_i.
// Notes:   A new level is accepted after max_filter+1 differing samples.
`timescale 1ns/1ps
module tbq_glitch_filter
  import tbq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       sig_i,
  input  wire logic [5:0] max_filter_i,
  output logic            sig_o
);

  logic [5:0] cnt_q;  // Samples seen that differ from the output

  // Count disagreeing samples; any agreeing sample restarts the count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= FILT_CNT_RST;
      sig_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sig_i == sig_o)
        cnt_q <= FILT_CNT_RST;
      else if (cnt_q >= max_filter_i)
      begin
        sig_o <= sig_i;
        cnt_q <= FILT_CNT_RST;
      end
      else
        cnt_q <= cnt_q + 6'h01;
    end
  end

  // A short pulse never reaches the output
  a_filter_holds: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && sig_i != sig_o && cnt_q < max_filter_i) |=> $stable(sig_o))
    else $error("filter passed a short pulse");

endmodule // tbq_glitch_filter

// File: hw/tbq_quad_decode.sv
// Purpose: Edge, direction, index and error detection on filtered phases.
// Assumes: Inputs already inverted, swapped and filtered.
// Notes:   Direction 0 means phase A leads phase B.
`timescale 1ns/1ps
module tbq_quad_decode
  import tbq_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic enable_i,
  input  wire logic both_edges_i,
  input  wire logic transparent_i,
  input  wire logic phase_a_i,
  input  wire logic phase_b_i,
  input  wire logic index_i,
  output logic      count_o,
  output logic      dir_o,
  output tbq_qevt_t evt_o
);

  logic pa_q;      // Previous phase A
  logic pb_q;      // Previous phase B
  logic pi_q;      // Previous index
  logic edge_a;    // Phase A toggled
  logic edge_b;    // Phase B toggled
  logic dir_new;   // Direction implied by this edge

  assign edge_a = phase_a_i ^ pa_q;
  assign edge_b = phase_b_i ^ pb_q;

  // Direction from which phase moved and the level of the other
  always_comb
  begin
    dir_new = dir_o;
    if (edge_a && !edge_b)
      dir_new = ~(phase_a_i ^ phase_b_i);
    else if (edge_b && !edge_a)
      dir_new = phase_a_i ^ phase_b_i;
  end

  // History tracks even while disabled, so enabling makes no false edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      pi_q <= 1'b0;
    end
    else if (ce_i)
    begin
      pa_q <= phase_a_i;
      pb_q <= phase_b_i;
      pi_q <= index_i;
    end
  end

  // Events and direction; all quiet while the decoder is off
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= 1'b0;
      dir_o   <= 1'b0;
      evt_o   <= '0;
    end
    else if (ce_i)
    begin
      count_o                <= enable_i &&
                                (both_edges_i ? (edge_a | edge_b) : edge_a);
      evt_o.quadrature_error <= enable_i && edge_a && edge_b;
      evt_o.index_input      <= enable_i && index_i && !pi_q;
      evt_o.direction_change <= enable_i && !transparent_i &&
                                (dir_new != dir_o);
      if (enable_i && !transparent_i)
        dir_o <= dir_new;
    end
  end

  // Transparent decoding never reports a direction change
  a_trans_nodir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && transparent_i) |=> !evt_o.direction_change)
    else $error("direction change while transparent");

endmodule // tbq_quad_decode

// File: hw/tbq_block_ctrl.sv
// Purpose: Block-level control of a three-channel timer: interrupt masks,
//          software sync, external clock routing and quadrature front end.
// Assumes: AHB-Lite slave with word transfers; pins synchronous to clk_i.
// Notes:   Reads take one wait state, writes none; response always OKAY.
`timescale 1ns/1ps

// Behaviour
// - Disable write of one clears mask bit
// - Overrun, load A/B disable only in capture
// - Compare A/B disable only in waveform
// - Mask register reads enabled sources
// - Enable write of one sets mask bit
// - Control bit 0 pulses sync to channels
// - Mode writes ignored while protected
// - External clock 0 source selection
// - External clock 1 source selection
// - External clock 2 source selection
// - Decoder enable activates decode; filters always run
// - Position enable uses channels 0 and 1
// - Speed enable on channel 0, base 2
// - Transparent mode drops direction detection
// - Edge mode selects phase A or both
// - Invert bits flip each decoder input
// - Swap exchanges phase A and B
// - Index source select picks pin
// - Filter drops pulses under max_filter+1 cycles
// - Decoder enable register sets irq enables
module tbq_block_ctrl
  import tbq_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            ce_i,
  // AHB-Lite slave
  input  wire logic            hsel_i,
  input  wire logic [31:0]     haddr_i,
  input  wire logic [1:0]      htrans_i,
  input  wire logic            hwrite_i,
  input  wire logic [2:0]      hsize_i,
  input  wire logic [31:0]     hwdata_i,
  input  wire logic            hready_i,
  output logic      [31:0]     hrdata_o,
  output logic                 hreadyout_o,
  output logic                 hresp_o,
  // Channel side
  input  wire logic [2:0][7:0] chan_status_i,
  input  wire logic [2:0]      chan_wave_i,
  output logic      [2:0]      chan_irq_o,
  output logic                 sync_trigger_o,
  // External clock routing
  input  wire logic [2:0]      clock_pin_i,
  input  wire logic [2:0]      chan_io_a_i,
  input  wire logic            chan0_io_b_i,
  output logic      [2:0]      ext_clk_o,
  // Quadrature decoder
  output tbq_mode_t            mode_o,
  output logic                 position_measure_o,
  output logic                 speed_measure_o,
  output logic                 count_pulse_o,
  output logic                 dir_o,
  output tbq_qevt_t            quadrature_decoder_event_o,
  output logic      [2:0]      quadrature_decoder_irq_mask_o
);

  // Data phase kinds of the bus slave
  typedef enum logic [1:0] {
    DPH_NONE,
    DPH_WRITE,
    DPH_RDWAIT,
    DPH_RDDONE
  } tbq_dph_t;

  logic            rst_meta_q;   // Reset release, first stage
  logic            rst_n_q;      // Reset used by all other logic
  tbq_dph_t        dph_q;        // Current data phase
  logic [31:0]     a_addr_q;     // Word address of the pending transfer
  logic            wr_en;        // Write data valid this cycle
  logic [2:0]      hit_ier;      // Per-channel enable register hit
  logic [2:0]      hit_idr;      // Per-channel disable register hit
  logic [2:0]      hit_imr;      // Per-channel mask register hit
  logic [31:0]     rd_word;      // Read value for the pending address
  logic [2:0][7:0] chan_mask_q;  // Per-channel interrupt masks
  logic [2:0]      qmask_q;      // Decoder interrupt masks
  tbq_mode_t       mode_q;       // Block mode
  logic            wp_q;         // Write protection enabled
  logic            pa_raw;       // Phase A after invert and swap
  logic            pb_raw;       // Phase B after invert and swap
  logic            idx_raw;      // Index after select and invert
  logic            pa_filt;      // Filtered phase A
  logic            pb_filt;      // Filtered phase B
  logic            idx_filt;     // Filtered index

  // Channel copies of a register, one-hot over the three channels
  function automatic logic [2:0] chan_hit(input logic [31:0] addr,
                                          input logic [31:0] ch0);
    logic [2:0] hit;
    hit = 3'h0;
    for (int i = 0; i < 3; i++)
      hit[i] = (addr == ch0 + 32'(i) * CH_STRIDE);
    return hit;
  endfunction

  // Clock source pick; code 1 is reserved and routes a quiet low
  function automatic logic xclk_pick(input logic [1:0] sel,
                                     input logic pin,
                                     input logic alt_lo,
                                     input logic alt_hi);
    case (sel)
      XSEL_PIN:    return pin;
      XSEL_ALT_LO: return alt_lo;
      XSEL_ALT_HI: return alt_hi;
      default:     return 1'b0;
    endcase
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Bus phase tracking; a read inserts one wait state so that read data
  // comes from a flop and already reflects a write just before it
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dph_q    <= DPH_NONE;
      a_addr_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (dph_q == DPH_RDWAIT)
        dph_q <= DPH_RDDONE;
      else if (hready_i && hsel_i && htrans_i[1])
      begin
        dph_q    <= hwrite_i ? DPH_WRITE : DPH_RDWAIT;
        a_addr_q <= {haddr_i[31:2], 2'h0};
      end
      else
        dph_q <= DPH_NONE;
    end
  end

  assign wr_en       = (dph_q == DPH_WRITE);
  assign hreadyout_o = (dph_q != DPH_RDWAIT);
  assign hresp_o     = 1'b0;
  assign hit_ier     = chan_hit(a_addr_q, ADDR_IER0);
  assign hit_idr     = chan_hit(a_addr_q, ADDR_IDR0);
  assign hit_imr     = chan_hit(a_addr_q, ADDR_IMR0);

  // Read value; write-only and unmapped addresses read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < 3; i++)
      if (hit_imr[i])
        rd_word = {24'h00_0000, chan_mask_q[i]};
    if (a_addr_q == ADDR_BMR)
      rd_word = mode_q;
    else if (a_addr_q == ADDR_QIMR)
      rd_word = {29'h0000_0000, qmask_q};
    else if (a_addr_q == ADDR_WPMR)
      rd_word = {31'h0000_0000, wp_q};
  end

  // Read data is loaded at the end of the wait state
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      hrdata_o <= 32'h0000_0000;
    else if (ce_i && dph_q == DPH_RDWAIT)
      hrdata_o <= rd_word;
  end

  // Channel masks: enable sets, disable clears; mode-specific disable
  // bits only act while the channel is in the matching mode
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      chan_mask_q <= {3{CHAN_MASK_RST}};
    else if (ce_i && wr_en)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (hit_ier[i])
          chan_mask_q[i] <= chan_mask_q[i] | hwdata_i[7:0];
        else if (hit_idr[i])
          chan_mask_q[i] <= chan_mask_q[i] & ~(hwdata_i[7:0] &
            (chan_wave_i[i] ? ~CAPTURE_ONLY : ~WAVE_ONLY));
      end
    end
  end

  // Channel interrupt: any flagged source that is enabled
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      chan_irq_o <= 3'h0;
    else if (ce_i)
      for (int i = 0; i < 3; i++)
        chan_irq_o[i] <= |(chan_status_i[i] & chan_mask_q[i]);
  end

  // Software sync: one-cycle pulse to all channels at once
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sync_trigger_o <= 1'b0;
    else if (ce_i)
      sync_trigger_o <= wr_en && (a_addr_q == ADDR_BCR) &&
                        hwdata_i[SYNC_BIT];
  end

  // Protection bit changes only with the unlock key in the same word
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      wp_q <= WP_RST;
    else if (ce_i && wr_en && a_addr_q == ADDR_WPMR &&
             hwdata_i[31:8] == WP_KEY)
      wp_q <= hwdata_i[WRITE_PROTECT_ENABLE_BIT];
  end

  // Block mode; reserved bits stay zero, writes dropped while protected
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      mode_q <= MODE_RST;
    else if (ce_i && wr_en && a_addr_q == ADDR_BMR && !wp_q)
      mode_q <= hwdata_i & MODE_WMASK;
  end

  // Decoder interrupt enables
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      qmask_q <= QMASK_RST;
    else if (ce_i && wr_en)
    begin
      if (a_addr_q == ADDR_QIER)
        qmask_q <= qmask_q | hwdata_i[2:0];
      else if (a_addr_q == ADDR_QIDR)
        qmask_q <= qmask_q & ~hwdata_i[2:0];
    end
  end

  // External clock routing, registered so the outputs cannot glitch
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ext_clk_o <= 3'h0;
    else if (ce_i)
    begin
      ext_clk_o[0] <= xclk_pick(mode_q.ext_clock0_select, clock_pin_i[0],
                                chan_io_a_i[1], chan_io_a_i[2]);
      ext_clk_o[1] <= xclk_pick(mode_q.ext_clock1_select, clock_pin_i[1],
                                chan_io_a_i[0], chan_io_a_i[2]);
      ext_clk_o[2] <= xclk_pick(mode_q.ext_clock2_select, clock_pin_i[2],
                                chan_io_a_i[0], chan_io_a_i[1]);
    end
  end

  // Measurement enables seen by the channels; software must set one
  // of them with the decoder, nothing here forces it
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      position_measure_o <= 1'b0;
      speed_measure_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      position_measure_o <= mode_q.decoder_enable &&
                            mode_q.position_enable;
      speed_measure_o    <= mode_q.decoder_enable &&
                            mode_q.speed_enable;
    end
  end

  // Input conditioning: invert each named input, then swap the phases
  assign pa_raw  = mode_q.swap ? (chan0_io_b_i ^ mode_q.invert_phase_b)
                               : (chan_io_a_i[0] ^ mode_q.invert_phase_a);
  assign pb_raw  = mode_q.swap ? (chan_io_a_i[0] ^ mode_q.invert_phase_a)
                               : (chan0_io_b_i ^ mode_q.invert_phase_b);
  assign idx_raw = (mode_q.index_source_select ? chan0_io_b_i
                                               : chan_io_a_i[1]) ^
                   mode_q.invert_index;

  // One filter per decoder input
  tbq_glitch_filter u_filt_a (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_q),
    .ce_i         (ce_i),
    .sig_i        (pa_raw),
    .max_filter_i (mode_q.max_filter),
    .sig_o        (pa_filt)
  );

  tbq_glitch_filter u_filt_b (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_q),
    .ce_i         (ce_i),
    .sig_i        (pb_raw),
    .max_filter_i (mode_q.max_filter),
    .sig_o        (pb_filt)
  );

  tbq_glitch_filter u_filt_idx (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_q),
    .ce_i         (ce_i),
    .sig_i        (idx_raw),
    .max_filter_i (mode_q.max_filter),
    .sig_o        (idx_filt)
  );

  // Decoder core, gated by the enable bit
  tbq_quad_decode u_decode (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_q),
    .ce_i          (ce_i),
    .enable_i      (mode_q.decoder_enable),
    .both_edges_i  (mode_q.edge_count_mode),
    .transparent_i (mode_q.transparent_decoding),
    .phase_a_i     (pa_filt),
    .phase_b_i     (pb_filt),
    .index_i       (idx_filt),
    .count_o       (count_pulse_o),
    .dir_o         (dir_o),
    .evt_o         (quadrature_decoder_event_o)
  );

  assign mode_o          = mode_q;
  assign quadrature_decoder_irq_mask_o = qmask_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_write(logic [31:0] addr);
    ce_i && wr_en && a_addr_q == addr;
  endsequence

  sequence s_imr_read;
    ce_i && dph_q == DPH_RDWAIT && a_addr_q == ADDR_IMR0;
  endsequence

  a_idr_clears: assert property (
    (s_write(ADDR_IDR0 + 2 * CH_STRIDE) and hwdata_i[0])
    |=> !chan_mask_q[2][0])
    else $error("disable did not clear overflow mask");
  a_capture_only_keep: assert property (
    (s_write(ADDR_IDR0 + 2 * CH_STRIDE) and (chan_wave_i[2] && hwdata_i[5]))
    |=> $stable(chan_mask_q[2][5]))
    else $error("load A mask cleared in waveform mode");
  a_wave_only_keep: assert property (
    (s_write(ADDR_IDR0 + 2 * CH_STRIDE) and (!chan_wave_i[2] && hwdata_i[2]))
    |=> $stable(chan_mask_q[2][2]))
    else $error("compare A mask cleared in capture mode");
  a_imr_readback: assert property (
    s_imr_read |=> (hreadyout_o &&
                    hrdata_o == {24'h00_0000, $past(chan_mask_q[0])}))
    else $error("mask read returned wrong value");
  a_ier_sets: assert property (
    (s_write(ADDR_IER0 + 2 * CH_STRIDE) and hwdata_i[7])
    |=> chan_mask_q[2][7])
    else $error("enable did not set trigger mask");
  a_sync_pulse: assert property (
    (s_write(ADDR_BCR) and hwdata_i[0]) |=> sync_trigger_o)
    else $error("sync command gave no pulse");
  a_mode_locked: assert property (
    (s_write(ADDR_BMR) and wp_q) |=> $stable(mode_q))
    else $error("mode changed while protected");
  a_xclk0_pin: assert property (
    (ce_i && mode_q.ext_clock0_select == XSEL_PIN)
    |=> ext_clk_o[0] == $past(clock_pin_i[0]))
    else $error("clock 0 not routed from pin");
  a_xclk1_rsvd: assert property (
    (ce_i && mode_q.ext_clock1_select == 2'h1) |=> !ext_clk_o[1])
    else $error("reserved clock 1 code not quiet");
  a_xclk2_alt: assert property (
    (ce_i && mode_q.ext_clock2_select == XSEL_ALT_HI)
    |=> ext_clk_o[2] == $past(chan_io_a_i[1]))
    else $error("clock 2 not routed from channel 1");
  a_decoder_off: assert property (
    (ce_i && !mode_q.decoder_enable)
    |=> (quadrature_decoder_event_o == '0 && !count_pulse_o))
    else $error("decoder active while disabled");
  a_qier_sets: assert property (
    (s_write(ADDR_QIER) and hwdata_i[2]) |=> qmask_q[2])
    else $error("decoder error enable not set");
  a_chan_irq: assert property (
    (ce_i && |(chan_status_i[2] & chan_mask_q[2])) |=> chan_irq_o[2])
    else $error("channel 2 interrupt missing");

endmodule // tbq_block_ctrl

// File: test/tbq_encoder.sv
// Purpose: Rotary encoder model driving phase A, phase B and index.
// Assumes: Steps once every dwell_i+1 clocks while go_i is high.
// Notes:   Forward turning, phase A leads phase B; glitch_i is a fault.
`timescale 1ns/1ps
module tbq_encoder
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       glitch_i,
  input  wire logic [3:0] dwell_i,
  output logic            pha_o,
  output logic            phb_o,
  output logic            idx_o
);
  logic [3:0] cnt = 4'h0;  // Dwell counter
  logic [5:0] pos = 6'h00; // Shaft position, 64 steps per turn
  // One step per dwell period; a slow dwell checks the filter latency
  always_ff @(posedge clk_i)
    if (go_i && cnt >= dwell_i)
    begin
      cnt <= 4'h0;
      pos <= pos + 6'h01;
    end
    else if (go_i)
      cnt <= cnt + 4'h1;
  // Gray code; the glitch flips phase A for as long as it is held
  assign pha_o = pos[1] ^ pos[0] ^ glitch_i;
  assign phb_o = pos[1];
  assign idx_o = (pos == 6'h00);
endmodule // tbq_encoder

// File: test/test_tbq_block_ctrl.sv
// Purpose: Self-checking bench for the timer block control.
// Assumes: AHB-Lite single word transfers; read results go via a queue.
// Notes:   Waits are bounded; a hung wait ends the run as a mismatch.
`timescale 1ns/1ps
module test_tbq_block_ctrl
  import tbq_pkg::*;
;
  logic clk_i = 0, reset_n_i = 0, hsel_i = 0, hwrite_i = 0, rdp = 0;
  logic [1:0] htrans_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, m32;
  logic [2:0][7:0] chan_status_i = '0;
  logic [2:0] chan_wave_i = 0, clock_pin_i = 0, chan_irq_o, ext_clk_o, p;
  logic hreadyout_o, sync_trigger_o, phase_a, phase_b, idx, a2 = 0, go = 0, gl = 0;
  logic position_measure_o, speed_measure_o, count_pulse_o, dir_o;
  logic [7:0] m = 0, ie, id, s;
  logic [31:0] q[$]; // Expected read data, oldest first
  logic [2:0] ev; // Decoder event pulses
  int ic = 0, dc = 0; // Index and direction change events seen
  int bad_count = 0, tests_run = 0, pc = 0, seed = 29;
  tbq_block_ctrl tbq_block_ctrl_inst (.clk_i, .reset_n_i, .ce_i(1'b1),
    .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o(),
    .chan_status_i, .chan_wave_i, .chan_irq_o, .sync_trigger_o,
    .clock_pin_i, .chan_io_a_i({a2, idx, phase_a}), .chan0_io_b_i(phase_b),
    .ext_clk_o, .mode_o(), .position_measure_o, .speed_measure_o,
    .count_pulse_o, .dir_o, .quadrature_decoder_event_o(ev), .quadrature_decoder_irq_mask_o());
  tbq_encoder tbq_encoder_inst (.clk_i, .go_i(go), .glitch_i(gl),
    .dwell_i(4'h5), .pha_o(phase_a), .phb_o(phase_b), .idx_o(idx));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] sn, ex);
    tests_run++;
    if (sn !== ex)
    begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, sn, ex);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for hready high, sampled mid-cycle where it is settled
  task automatic waitr();
    int n = 0;
    @(negedge clk_i);
    while (!hreadyout_o && n < 50)
    begin
      n++;
      @(negedge clk_i);
    end
    if (n == 50)
    begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    hsel_i <= 1; haddr_i <= a; hwrite_i <= w; htrans_i <= 2'h2;
    waitr(); @(posedge clk_i);
    htrans_i <= 2'h0; hwdata_i <= d; rdp <= !w;
    waitr(); @(posedge clk_i);
    rdp <= 0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  function automatic logic f(input logic [1:0] c, input logic pn, lo, hi);
    return c == 2'h0 ? pn : c == 2'h2 ? lo : c == 2'h3 ? hi : 1'b0;
  endfunction
  // Read data monitor: compare mid-cycle in the last data phase cycle of each read, once hready is high
  always @(negedge clk_i)
    if (rdp && hreadyout_o) chk(hrdata_o, q.pop_front());
  always @(negedge clk_i) if (count_pulse_o === 1'b1) pc++;
  always @(negedge clk_i)
  begin
    ic += (ev[0] === 1'b1);
    dc += (ev[1] === 1'b1);
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1;
    repeat (3) @(posedge clk_i);
    rd(ADDR_IMR0, 32'h0);
    // Random enable, disable, waveform mode and status on channel 2
    repeat (6)
    begin
      @(posedge clk_i);
      {ie, id, s} = $random(seed);
      p = $random(seed);
      chan_wave_i[2] <= p[0]; chan_status_i[2] <= s;
      bus(1, ADDR_IER0 + 2 * CH_STRIDE, {24'h0, ie});
      bus(1, ADDR_IDR0 + 2 * CH_STRIDE, {24'h0, id});
      m = (m | ie) & ~(id & (p[0] ? ~CAPTURE_ONLY : ~WAVE_ONLY));
      rd(ADDR_IMR0 + 2 * CH_STRIDE, {24'h0, m});
      @(negedge clk_i) chk(chan_irq_o[2], |(s & m));
    end
    bus(1, ADDR_BCR, 32'h0);
    @(negedge clk_i) chk(sync_trigger_o, 0);
    bus(1, ADDR_BCR, 32'h1);
    @(negedge clk_i) chk(sync_trigger_o, 1);
    @(negedge clk_i) chk(sync_trigger_o, 0);
    bus(1, ADDR_WPMR, {24'h123456, 8'h01});
    rd(ADDR_WPMR, 32'h0);
    bus(1, ADDR_WPMR, {WP_KEY, 8'h01});
    bus(1, ADDR_BMR, 32'h0000_0003);
    rd(ADDR_BMR, 32'h0);
    bus(1, ADDR_WPMR, {WP_KEY, 8'h00});
    bus(1, ADDR_QIER, 32'h5);
    rd(ADDR_QIMR, 32'h5);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_i);
      p = $random(seed);
      clock_pin_i <= p; a2 <= p[1];
      bus(1, ADDR_BMR, {26'h0, c[1:0], c[1:0], c[1:0]});
      repeat (3) @(negedge clk_i);
      chk(ext_clk_o, {f(c, p[2], phase_a, idx), f(c, p[1], phase_a, a2),
        f(c, p[0], idx, a2)});
    end
    // Decoder: filter of 2, edge mode and swap walked through
    for (int k = 0; k < 4; k++)
    begin
      m32 = 32'h0020_0300 | (k[0] ? 32'h1000 : 0) | (k[1] ? 32'h1_0400 : 0);
      bus(1, ADDR_BMR, m32);
      rd(ADDR_BMR, m32 & MODE_WMASK);
      pc = 0; go <= 1;
      repeat (192) @(posedge clk_i);
      go <= 0;
      repeat (10) @(negedge clk_i);
      chk(pc, k[0] ? 32 : 16);
      chk(dir_o, k[1]);
      chk({position_measure_o, speed_measure_o}, {1'b1, k[1]});
    end
    chk(ic, 2);
    chk(dc, 1);
    @(posedge clk_i);
    pc = 0; gl <= 1;
    @(posedge clk_i) gl <= 0;
    repeat (10) @(negedge clk_i);
    chk(pc, 0);
    conclude();
  end
endmodule // test_tbq_block_ctrl
